// [core/qdu_update_control.sv]
// What this block does
// - Channels 0,1 form group A; 2,3 group B.
// - Per-channel signed gain and zero trim registers.
// - Bipolar scale uses gain divisor eight times 16384.
// - Unipolar scale uses gain divisor four times 16384.
// - Bipolar input code is signed twos complement.
// - Unipolar input code is unsigned straight binary.
// - Gain trim limited to -128 through +127.
// - Zero trim limited to -256 through +255.
// - Read-back returns data in written format.
// - Group range pin high unipolar, low bipolar.
// - Gain select bits, one means four, reset one.
// - Valid frame writes input register; output follows latch.
// - Load event reloads only channels written since.
// - Load pin low during frame updates latch too.
// - Load pin high updates input register only.
// - Reset pin forces defaults and ignores serial pins.
// - After reset outputs hold reset level until programmed.
// - Software reset bit acts as reset, self-clears.
// - Power-on loads code zero in either range, outputs zero.
// - 24-bit frames, MSB first, falling edge, commit on rise.
// - Short frames discarded; long frames keep last 24.
module qdu_update_control
  import qdu_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         serialClock,
  input  wire logic         chipSelect_n,
  input  wire logic         serialData,
  input  wire logic         latchLoad_n,
  input  wire logic         resetPin_n,
  input  wire logic         rangeSelectGroupA,
  input  wire logic         rangeSelectGroupB,
  input  wire logic [3:0]   readAddr,
  output logic [13:0]       readData,
  output qdu_codes_t        latchCode,
  output qdu_codes_t        gainTrim,
  output qdu_codes_t        zeroTrim,
  output logic [3:0]        gainSelect,
  output logic [3:0]        unipolarMode,
  output qdu_trimmed_t      trimmedCode,
  output logic [3:0]        writtenSinceLoad
);

  // Link domain: the shift register runs on the serial clock alone.
  logic [FRAME_BITS-1:0] shift_r;
  logic [CNT_W-1:0]      edgeCount_r;
  logic                  frameFresh_r;
  logic                  freshSeen_r;

  // At each chip select fall the fresh flag takes the inverse of the
  // link side's copy, so the first falling edge of every frame sees them
  // differ and restarts the count. A frame with no edge at all leaves
  // them differing, which the system side treats as a short frame. The
  // serial clock is idle whenever either flop reads the other.
  always_ff @(negedge chipSelect_n or negedge rst_b) begin
    if (!rst_b) begin
      frameFresh_r <= 1'b0;
    end else begin
      frameFresh_r <= !freshSeen_r;
    end
  end

  always_ff @(negedge serialClock or negedge rst_b) begin
    if (!rst_b) begin
      freshSeen_r <= 1'b0;
    end else if (!chipSelect_n) begin
      freshSeen_r <= frameFresh_r;
    end
  end

  logic [CNT_W-1:0] countNext;

  always_comb begin
    if (frameFresh_r != freshSeen_r || edgeCount_r == '0) begin
      countNext = CNT_W'(1);
    end else if (edgeCount_r < CNT_W'(FRAME_BITS)) begin
      countNext = edgeCount_r + CNT_W'(1);
    end else begin
      countNext = edgeCount_r;
    end
  end

  // Bits shift in MSB first on the falling edge; only the last 24 stay.
  always_ff @(negedge serialClock or negedge rst_b) begin
    if (!rst_b) begin
      shift_r     <= '0;
      edgeCount_r <= '0;
    end else if (!chipSelect_n) begin
      shift_r     <= {shift_r[FRAME_BITS-2:0], serialData};
      edgeCount_r <= countNext;
    end
  end

  // System domain: synchronise pins.
  logic [1:0] csSync_r;
  logic [1:0] loadSync_r;
  logic [1:0] rstPinSync_r;
  logic [1:0] rangeASync_r;
  logic [1:0] rangeBSync_r;
  logic       csDelayed_r;
  logic       loadDelayed_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      csSync_r      <= 2'h3;
      loadSync_r    <= 2'h3;
      rstPinSync_r  <= 2'h0;
      rangeASync_r  <= 2'h0;
      rangeBSync_r  <= 2'h0;
      csDelayed_r   <= 1'b1;
      loadDelayed_r <= 1'b1;
    end else begin
      csSync_r      <= {csSync_r[0], chipSelect_n};
      loadSync_r    <= {loadSync_r[0], latchLoad_n};
      rstPinSync_r  <= {rstPinSync_r[0], resetPin_n};
      rangeASync_r  <= {rangeASync_r[0], rangeSelectGroupA};
      rangeBSync_r  <= {rangeBSync_r[0], rangeSelectGroupB};
      csDelayed_r   <= csSync_r[1];
      loadDelayed_r <= loadSync_r[1];
    end
  end

  logic softReset_r;
  logic resetAll;
  logic csRise;
  logic loadFall;

  assign resetAll = !rstPinSync_r[1] || softReset_r;
  assign csRise   = csSync_r[1] && !csDelayed_r;
  assign loadFall = !loadSync_r[1] && loadDelayed_r;

  // A frame that overlaps a reset is dropped even if it ends after it,
  // since some of its bits arrived while the serial pins were ignored.
  logic frameTainted_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frameTainted_r <= 1'b0;
    end else if (resetAll && !csSync_r[1]) begin
      frameTainted_r <= 1'b1;
    end else if (csRise) begin
      frameTainted_r <= 1'b0;
    end
  end

  // The frame word is stable here: the serial clock is blocked while
  // chip select is high and the next frame starts long after.
  qdu_frame_s frame;
  logic       frameValid;
  logic       commit;

  assign frame      = qdu_frame_s'(shift_r);
  assign frameValid = edgeCount_r == CNT_W'(FRAME_BITS)
                      && frameFresh_r == freshSeen_r;
  assign commit     = csRise && frameValid && !frame.rw && !resetAll
                      && !frameTainted_r;

  logic       cmdWrite;
  logic [1:0] chanSel;
  logic       inputWrite;
  logic       zeroWrite;
  logic       gainWrite;

  assign cmdWrite   = commit && frame.addr == ADDR_COMMAND;
  assign chanSel    = frame.addr[1:0];
  assign inputWrite = commit && frame.addr[3:2] == ADDR_INPUT0[3:2];
  assign zeroWrite  = commit && frame.addr[3:2] == ADDR_ZERO0[3:2];
  assign gainWrite  = commit && frame.addr[3:2] == ADDR_GAIN0[3:2];

  // Command register; the load and reset bits never read back as one.
  logic [CODE_W-1:0] command_r;
  logic              loadBitPulse_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      command_r <= CMD_RESET_VALUE;
    end else if (resetAll) begin
      command_r <= CMD_RESET_VALUE;
    end else if (cmdWrite) begin
      command_r <= frame.data;
      command_r[CMD_SOFT_RESET_BIT] <= 1'b0;
      command_r[CMD_LOAD_BIT]       <= 1'b0;
    end
  end

  // Software reset lasts one cycle and clears itself.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      softReset_r <= 1'b0;
    end else begin
      softReset_r <= cmdWrite && frame.data[CMD_SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loadBitPulse_r <= 1'b0;
    end else begin
      loadBitPulse_r <= cmdWrite && frame.data[CMD_LOAD_BIT];
    end
  end

  logic loadEvent;
  logic loadHeldLow;

  assign loadEvent   = loadFall || loadBitPulse_r;
  assign loadHeldLow = !loadSync_r[1];

  // Trim saturation to the accepted ranges.
  logic signed [CODE_W-1:0] dataSigned;
  logic [CODE_W-1:0]        gainClamped;
  logic [CODE_W-1:0]        zeroClamped;

  assign dataSigned = frame.data;

  always_comb begin
    if (dataSigned < GAIN_TRIM_MIN) begin
      gainClamped = GAIN_TRIM_MIN;
    end else if (dataSigned > GAIN_TRIM_MAX) begin
      gainClamped = GAIN_TRIM_MAX;
    end else begin
      gainClamped = frame.data;
    end
  end

  always_comb begin
    if (dataSigned < ZERO_TRIM_MIN) begin
      zeroClamped = ZERO_TRIM_MIN;
    end else if (dataSigned > ZERO_TRIM_MAX) begin
      zeroClamped = ZERO_TRIM_MAX;
    end else begin
      zeroClamped = frame.data;
    end
  end

  qdu_codes_t inputCode_r;
  qdu_codes_t latchCode_r;
  qdu_codes_t gainTrim_r;
  qdu_codes_t zeroTrim_r;
  logic [CH_COUNT-1:0] written_r;

  genvar ch;
  generate
    for (ch = 0; ch < CH_COUNT; ch++) begin : gChan
      logic hit;
      logic directLoad;
      logic reload;
      logic groupUni;

      assign hit        = chanSel == 2'(ch);
      assign directLoad = inputWrite && hit && loadHeldLow;
      assign reload     = loadEvent && written_r[ch];
      assign groupUni   = (ch < CH_COUNT / 2) ? rangeASync_r[1]
                                              : rangeBSync_r[1];

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          inputCode_r[ch] <= CODE_RESET_VALUE;
        end else if (resetAll) begin
          inputCode_r[ch] <= CODE_RESET_VALUE;
        end else if (inputWrite && hit) begin
          inputCode_r[ch] <= frame.data;
        end
      end

      // The latch only moves on a load, so reset level holds until a
      // new code is both written and loaded.
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          latchCode_r[ch] <= CODE_RESET_VALUE;
        end else if (resetAll) begin
          latchCode_r[ch] <= CODE_RESET_VALUE;
        end else if (directLoad) begin
          latchCode_r[ch] <= frame.data;
        end else if (reload) begin
          latchCode_r[ch] <= inputCode_r[ch];
        end
      end

      // A write while the load pin is low, including the cycle it falls, loads the latch and clears the flag.
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          written_r[ch] <= 1'b0;
        end else if (resetAll) begin
          written_r[ch] <= 1'b0;
        end else if (inputWrite && hit) begin
          written_r[ch] <= !loadHeldLow;
        end else if (reload) begin
          written_r[ch] <= 1'b0;
        end
      end

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          gainTrim_r[ch] <= CODE_RESET_VALUE;
          zeroTrim_r[ch] <= CODE_RESET_VALUE;
        end else if (resetAll) begin
          gainTrim_r[ch] <= CODE_RESET_VALUE;
          zeroTrim_r[ch] <= CODE_RESET_VALUE;
        end else begin
          if (gainWrite && hit) begin
            gainTrim_r[ch] <= gainClamped;
          end
          if (zeroWrite && hit) begin
            zeroTrim_r[ch] <= zeroClamped;
          end
        end
      end

      // Scaled code in units of 1/32 LSB. Unipolar doubles the gain
      // term, which equals dividing by 4*16384 instead of 8*16384.
      logic signed [TRIM_OUT_W-1:0] codeTerm;
      logic signed [TRIM_OUT_W-1:0] base;
      logic signed [18:0]           factor;
      logic signed [39:0]           product;
      logic signed [18:0]           gainExt;
      logic signed [TRIM_OUT_W-1:0] zeroExt;

      assign gainExt  = 19'(signed'(gainTrim_r[ch]));
      assign zeroExt  = TRIM_OUT_W'(signed'(zeroTrim_r[ch]));
      assign codeTerm = groupUni
        ? TRIM_OUT_W'({1'b0, latchCode_r[ch]}) <<< ZERO_SHIFT
        : TRIM_OUT_W'(signed'(latchCode_r[ch])) <<< ZERO_SHIFT;
      assign base     = codeTerm + zeroExt;
      assign factor   = groupUni ? GAIN_UNITY + (gainExt <<< 1)
                                 : GAIN_UNITY + gainExt;
      assign product  = 40'(base) * 40'(factor);

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          trimmedCode[ch] <= '0;
        end else begin
          trimmedCode[ch] <= product[GAIN_SHIFT+TRIM_OUT_W-1:GAIN_SHIFT];
        end
      end

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          unipolarMode[ch] <= 1'b0;
        end else begin
          unipolarMode[ch] <= groupUni;
        end
      end
    end
  endgenerate

  // Stored words are the written words after trim saturation and command bit clearing, so read-back keeps the format.
  logic [CODE_W-1:0] readNext;

  always_comb begin
    case (readAddr[3:2])
      ADDR_INPUT0[3:2]: readNext = inputCode_r[readAddr[1:0]];
      ADDR_ZERO0[3:2]:  readNext = zeroTrim_r[readAddr[1:0]];
      ADDR_GAIN0[3:2]:  readNext = gainTrim_r[readAddr[1:0]];
      default:          readNext = (readAddr == ADDR_COMMAND)
                                   ? command_r : '0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      readData <= '0;
    end else begin
      readData <= readNext;
    end
  end

  assign latchCode        = latchCode_r;
  assign gainTrim         = gainTrim_r;
  assign zeroTrim         = zeroTrim_r;
  assign gainSelect       = command_r[CMD_GAIN_SEL_LSB +: CH_COUNT];
  assign writtenSinceLoad = written_r;

endmodule

// [pkg/qdu_pkg.sv]
package qdu_pkg;

  localparam int CH_COUNT   = 4;
  localparam int CODE_W     = 14;
  localparam int ADDR_W     = 4;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W      = 5;
  localparam int TRIM_OUT_W = 21;

  // Frame field positions, most significant bit sent first.
  localparam int FRAME_RW_BIT   = 23;
  localparam int FRAME_ADDR_MSB = 22;
  localparam int FRAME_ADDR_LSB = 19;
  localparam int FRAME_DATA_MSB = 13;

  // Register addresses carried in the frame.
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_INPUT0  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_ZERO0   = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_GAIN0   = 4'hc;

  // Command register fields and reset value.
  localparam int CMD_SOFT_RESET_BIT = 13;
  localparam int CMD_LOAD_BIT       = 12;
  localparam int CMD_GAIN_SEL_LSB   = 8;
  localparam logic [CODE_W-1:0] CMD_RESET_VALUE = 14'h0f00;
  localparam logic [CODE_W-1:0] CODE_RESET_VALUE = 14'h0000;

  // Trim code limits, twos complement.
  localparam logic signed [CODE_W-1:0] GAIN_TRIM_MIN = -14'sd128;
  localparam logic signed [CODE_W-1:0] GAIN_TRIM_MAX = 14'sd127;
  localparam logic signed [CODE_W-1:0] ZERO_TRIM_MIN = -14'sd256;
  localparam logic signed [CODE_W-1:0] ZERO_TRIM_MAX = 14'sd255;

  // Scaling: zero trim is 1/32 LSB, gain divisor 8*16384 or 4*16384.
  localparam int ZERO_SHIFT = 5;
  localparam int GAIN_SHIFT = 17;
  localparam logic signed [18:0] GAIN_UNITY = 19'sd131072;

  typedef struct packed {
    logic                rw;
    logic [ADDR_W-1:0]   addr;
    logic [4:0]          reserved;
    logic [CODE_W-1:0]   data;
  } qdu_frame_s;

  typedef logic [CH_COUNT-1:0][CODE_W-1:0]     qdu_codes_t;
  typedef logic [CH_COUNT-1:0][TRIM_OUT_W-1:0] qdu_trimmed_t;

endpackage

// [tb/qdu_spi_host.sv]
module qdu_spi_host (
  output logic serialClock,
  output logic chipSelect_n,
  output logic serialData
);
  timeunit 1ns;
  timeprecision 100ps;

  // The clock idles high so the first edge of a frame is a falling one.
  initial begin
    serialClock = 1'b1;
    chipSelect_n = 1'b1;
    serialData = 1'b0;
  end

  // Bits above the 24th are filler sent ahead of the real frame.
  task automatic sendFrame(input logic [23:0] frame, input int edges);
    logic b;
    b = 1'b0;
    chipSelect_n = 1'b0;
    for (int i = edges - 1; i >= 0; i--) begin
      b = (i < 24) ? frame[i] : ~frame[23];
      serialData = b;
      #20 serialClock = 1'b0;
      #40 serialClock = 1'b1;
      #20;
    end
    chipSelect_n = 1'b1;
    // A released line must not keep showing the last bit.
    serialData = ~b;
    #100;
  endtask
endmodule

// [tb/qdu_update_control_asserts.sv]
module qdu_update_control_asserts
  import qdu_pkg::*;
(
  input wire logic         clock,
  input wire logic         rst_b,
  input wire logic         chipSelect_n,
  input wire logic         latchLoad_n,
  input wire logic         resetPin_n,
  input wire logic         rangeSelectGroupA,
  input wire logic         rangeSelectGroupB,
  input wire logic [3:0]   readAddr,
  input wire logic [13:0]  readData,
  input wire qdu_codes_t   latchCode,
  input wire qdu_codes_t   gainTrim,
  input wire qdu_codes_t   zeroTrim,
  input wire logic [3:0]   gainSelect,
  input wire logic [3:0]   unipolarMode,
  input wire qdu_trimmed_t trimmedCode,
  input wire logic [3:0]   writtenSinceLoad
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence csIdle;
    chipSelect_n [*8];
  endsequence
  sequence pinReset;
    !resetPin_n [*4];
  endsequence

  a_reset_zero: assert property (
    pinReset |-> latchCode == '0 && writtenSinceLoad == '0)
    else $error("pin reset left codes or flags set");
  a_reset_gain_sel: assert property (
    (pinReset ##1 resetPin_n) |-> gainSelect == 4'hf)
    else $error("gain select not four after reset");
  a_idle_hold: assert property (
    csIdle ##0 (writtenSinceLoad == '0 && resetPin_n)
    |=> $stable(latchCode))
    else $error("clean latch changed");
  a_load_clears: assert property (
    csIdle ##0 $fell(latchLoad_n) ##1 chipSelect_n [*4]
    |=> writtenSinceLoad == '0)
    else $error("load left flags set");
  a_mode_groups: assert property (
    (resetPin_n && $stable(rangeSelectGroupA)
     && $stable(rangeSelectGroupB)) [*6]
    |-> unipolarMode == {{2{rangeSelectGroupB}}, {2{rangeSelectGroupA}}})
    else $error("channel mode does not follow group pin");
  a_read_unmapped: assert property (
    readAddr inside {4'h1, 4'h2, 4'h3} |=> readData == '0)
    else $error("unmapped read not zero");

  for (genvar i = 0; i < CH_COUNT; i++) begin : g_ch
    a_gain_range: assert property (
      $signed(gainTrim[i]) >= GAIN_TRIM_MIN
      && $signed(gainTrim[i]) <= GAIN_TRIM_MAX)
      else $error("gain trim out of range");
    a_zero_range: assert property (
      $signed(zeroTrim[i]) >= ZERO_TRIM_MIN
      && $signed(zeroTrim[i]) <= ZERO_TRIM_MAX)
      else $error("zero trim out of range");
    a_trim_scale: assert property (
      (gainTrim[i] == '0 && zeroTrim[i] == '0 && $stable(latchCode[i])
       && $stable(unipolarMode[i])) [*2]
      |-> trimmedCode[i] == (unipolarMode[i]
        ? 21'(latchCode[i]) << 5
        : 21'($signed(latchCode[i])) << 5))
      else $error("untrimmed scale wrong");
  end
endmodule

bind qdu_update_control qdu_update_control_asserts u_chk (
  .clock(clock), .rst_b(rst_b), .chipSelect_n(chipSelect_n),
  .latchLoad_n(latchLoad_n), .resetPin_n(resetPin_n),
  .rangeSelectGroupA(rangeSelectGroupA),
  .rangeSelectGroupB(rangeSelectGroupB),
  .readAddr(readAddr), .readData(readData), .latchCode(latchCode),
  .gainTrim(gainTrim), .zeroTrim(zeroTrim), .gainSelect(gainSelect),
  .unipolarMode(unipolarMode), .trimmedCode(trimmedCode),
  .writtenSinceLoad(writtenSinceLoad)
);

// [tb/tb.sv]
module tb
  import qdu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock, rst_b, latchLoad_n, resetPin_n, rangeA, rangeB;
  logic serialClock, chipSelect_n, serialData;
  logic [3:0] readAddr, gainSelect, unipolarMode, written;
  logic [13:0] readData;
  qdu_codes_t latchCode, gainTrim, zeroTrim;
  qdu_trimmed_t trimmedCode;
  int errors, comparisons;

  qdu_spi_host u_host (.serialClock(serialClock),
    .chipSelect_n(chipSelect_n), .serialData(serialData));

  qdu_update_control u_dut (.clock(clock), .rst_b(rst_b),
    .serialClock(serialClock), .chipSelect_n(chipSelect_n),
    .serialData(serialData), .latchLoad_n(latchLoad_n),
    .resetPin_n(resetPin_n), .rangeSelectGroupA(rangeA),
    .rangeSelectGroupB(rangeB), .readAddr(readAddr), .readData(readData),
    .latchCode(latchCode), .gainTrim(gainTrim), .zeroTrim(zeroTrim),
    .gainSelect(gainSelect), .unipolarMode(unipolarMode),
    .trimmedCode(trimmedCode), .writtenSinceLoad(written));

  always #2 clock = ~clock;

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [63:0] e,
                       input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [13:0] d);
    u_host.sendFrame({1'b0, a, 5'h00, d}, 24);
    tick(2);
  endtask

  task automatic rd(input logic [3:0] a, input logic [13:0] e);
    @(posedge clock) readAddr <= a;
    tick(2);
    check("readData", e, readData);
  endtask

  task automatic setPins(input logic ld, input logic rp, input logic a,
                         input logic b);
    @(posedge clock);
    latchLoad_n <= ld;
    resetPin_n <= rp;
    rangeA <= a;
    rangeB <= b;
    tick(6);
  endtask

  initial begin
    #200000;
    errors++;
    conclude();
  end

  initial begin
    {clock, rst_b, rangeA, rangeB} = 4'h0;
    {latchLoad_n, resetPin_n} = 2'b11;
    readAddr = 4'h0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    tick(8);
    check("gainSelect", 4'hf, gainSelect);
    check("latches", 0, latchCode);
    rd(ADDR_COMMAND, CMD_RESET_VALUE);
    rd(4'h1, 14'h0000);
    setPins(1'b1, 1'b1, 1'b1, 1'b0);
    check("mode", 4'b0011, unipolarMode);
    setPins(1'b1, 1'b1, 1'b0, 1'b1);
    check("mode", 4'b1100, unipolarMode);
    setPins(1'b1, 1'b1, 1'b0, 1'b0);
    wr(ADDR_INPUT0, 14'h0100);
    wr(4'h6, 14'h3fff);
    check("latches", 0, latchCode);
    check("written", 4'b0101, written);
    rd(4'h6, 14'h3fff);
    setPins(1'b0, 1'b1, 1'b0, 1'b0);
    setPins(1'b1, 1'b1, 1'b0, 1'b0);
    check("latches", {14'h0000, 14'h3fff, 14'h0000, 14'h0100}, latchCode);
    check("written", 4'b0000, written);
    check("trim0", 21'h002000, trimmedCode[0]);
    check("trim2", 21'h1fffe0, trimmedCode[2]);
    setPins(1'b0, 1'b1, 1'b0, 1'b0);
    wr(4'h5, 14'h0abc);
    setPins(1'b1, 1'b1, 1'b0, 1'b0);
    check("latch1", 14'h0abc, latchCode[1]);
    check("written", 4'b0000, written);
    wr(4'h7, 14'h1234);
    check("latch3", 14'h0000, latchCode[3]);
    wr(ADDR_COMMAND, 14'h1500);
    check("latch3", 14'h1234, latchCode[3]);
    check("gainSelect", 4'h5, gainSelect);
    rd(ADDR_COMMAND, 14'h0500);
    wr(ADDR_GAIN0, 14'h3f00);
    rd(ADDR_GAIN0, 14'h3f80);
    wr(4'h9, 14'h0200);
    rd(4'h9, 14'h00ff);
    check("trim0", 21'h001ff8, trimmedCode[0]);
    check("trim1", 21'h01587f, trimmedCode[1]);
    setPins(1'b1, 1'b1, 1'b1, 1'b0);
    check("trim0", 21'h001ff0, trimmedCode[0]);
    u_host.sendFrame({1'b0, ADDR_INPUT0, 5'h00, 14'h0055}, 20);
    rd(ADDR_INPUT0, 14'h0100);
    u_host.sendFrame({1'b0, ADDR_INPUT0, 5'h00, 14'h0077}, 30);
    rd(ADDR_INPUT0, 14'h0077);
    u_host.sendFrame({1'b1, ADDR_INPUT0, 5'h00, 14'h0011}, 24);
    rd(ADDR_INPUT0, 14'h0077);
    setPins(1'b1, 1'b0, 1'b0, 1'b0);
    wr(4'h5, 14'h0222);
    setPins(1'b1, 1'b1, 1'b0, 1'b0);
    check("latches", 0, latchCode);
    check("gainTrim", 0, gainTrim);
    check("zeroTrim", 0, zeroTrim);
    rd(4'h5, 14'h0000);
    wr(ADDR_INPUT0, 14'h0033);
    setPins(1'b0, 1'b1, 1'b0, 1'b0);
    setPins(1'b1, 1'b1, 1'b0, 1'b0);
    check("latch0", 14'h0033, latchCode[0]);
    wr(ADDR_COMMAND, 14'h2000);
    check("latches", 0, latchCode);
    check("gainSelect", 4'hf, gainSelect);
    rd(ADDR_COMMAND, CMD_RESET_VALUE);
    conclude();
  end
endmodule
